// [hw/csd_pkg.sv]
// constants, register map and types of the chip-select and bus-sizing unit
package csd_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word per register)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_START = 8'h00;   // area n start value at +4*n
  localparam logic [7:0] OFS_MASK = 8'h10;    // area n compare mask at +4*n
  localparam logic [7:0] OFS_CTRL = 8'h20;    // area n control at +4*n
  localparam logic [7:0] OFS_DEFAULT = 8'h30; // default-area control
  localparam logic [7:0] OFS_STATUS = 8'h34;  // unit state, read only
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_WAIT_LO = 0;
  localparam int CTL_WAIT_HI = 1;
  localparam int CTL_BUSW = 2;   // 0: 16-bit area, 1: 8-bit area
  localparam int CTL_WAVE = 3;   // area 3 only: 0 select, 1 column strobe
  localparam int CTL_EN = 4;
  localparam int CTL_MODE = 5;   // area 2 only: 0 whole space, 1 start/mask
  localparam logic [7:0] CTRL_WMASK [4] = '{8'h17, 8'h17, 8'h37, 8'h1F};
  localparam logic [7:0] DEF_WMASK = 8'h07;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] START_RST = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h10;   // area 2 enabled, whole space
  localparam logic [7:0] DEF_RST = 8'h00;
  // ---------------------------------------------------------------
  // address ranges and codes
  // ---------------------------------------------------------------
  localparam logic [23:0] WHOLE_LO = 24'h00_0080;
  localparam logic [23:0] WHOLE_HI = 24'hFF_FFFF;
  localparam logic [23:0] IO_TOP_DEF = 24'h00_0080;  // internal I/O below this
  localparam logic [1:0] WAIT_TWO = 2'b00;
  localparam logic [1:0] WAIT_ONE = 2'b01;
  localparam logic [1:0] WAIT_PIN = 2'b10;
  localparam logic [1:0] WAIT_NONE = 2'b11;
  localparam logic [1:0] SZ_BYTE = 2'd0;
  localparam logic [1:0] SZ_HALF = 2'd1;
  localparam logic [1:0] SZ_WORD = 2'd2;
  localparam logic [2:0] AREA_DEFAULT = 3'd4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC = 3'b001,
    ST_ADDR = 3'b010,
    ST_STRB = 3'b011,
    ST_IO = 3'b100
  } csd_state_t;
endpackage : csd_pkg

// [hw/csd_chip_select.sv]
// chip-select decoder, wait control and dynamic bus sizing with AHB-Lite registers
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - area-3 control bit 3 picks plain select (0) or column strobe (1) waveform
// - reset clears the waveform bit, so area 3 starts as a plain select
// - operands split into byte/word cycles, low bytes first, odd bytes on upper lane of a 16-bit area
// - unused lanes: read data ignored, write lanes undriven with strobe inactive
// - unmatched addresses use the always-on default-area width and wait settings
// - area-2 mode 0: select 2 covers 000080h to FFFFFFh, start/mask unused
// - area-2 mode 1: select 2 decodes from its own start and mask
// - reset clears the area-2 mode bit
// - each cycle compare address with start, masked bits ignored; enabled match drives low
// - overlapping enabled areas: lowest area number wins, whole-space area 2 included
// - internal I/O addresses are served inside and beat any external area
// - start value holds A23..A16; start bits for A15..A8 are fixed zero
// - mask bit 1 excludes its address bit; top bits are always compared
// - reset sets start and mask to FFh, disables areas 0,1,3, enables area 2
// - start points fall on 64K boundaries, masks may move the effective start
// - wait field: 00 two waits, 01 one, 10 one then hold on wait pin, 11 none
// - width bit 0 is 16-bit, 1 is 8-bit; width pin high forces 8-bit
// - control bit 4 enables the area's settings and select output
// - compared bits: area0 A8..A20, area1 A8..A21, areas 2/3 A15..A22 plus A23
module csd_chip_select
  import csd_pkg::*;
#(
  parameter logic [23:0] IO_TOP = csd_pkg::IO_TOP_DEF  // first address above internal I/O
) (
  input wire logic clk,                    // system clock
  input wire logic sys_rst,                // synchronous reset, active high
  input wire logic hsel,                   // AHB-Lite slave select
  input wire logic [31:0] haddr,           // AHB-Lite address
  input wire logic [1:0] htrans,           // AHB-Lite transfer type
  input wire logic hwrite,                 // AHB-Lite write
  input wire logic [2:0] hsize,            // AHB-Lite size, words only
  input wire logic [31:0] hwdata,          // AHB-Lite write data
  input wire logic hready,                 // AHB-Lite bus ready
  output logic hreadyout,                  // always ready
  output logic [31:0] hrdata,              // AHB-Lite read data
  output logic hresp,                      // always OKAY
  input wire logic cpuReq,                 // start an operand access, one cycle
  input wire logic [23:0] cpuAddr,         // operand address
  input wire logic cpuWrite,               // 1 write, 0 read
  input wire logic [1:0] cpuSize,          // 0 byte, 1 half, 2 word
  input wire logic [31:0] cpuWdata,        // operand to write, low byte first
  output logic cpuDone,                    // operand finished, one cycle
  output logic [31:0] cpuRdata,            // operand read, valid with cpuDone
  output logic ioSel,                      // internal I/O access, one cycle
  output logic [23:0] extAddr,             // external address
  output logic [3:0] areaSelectN,          // area selects, bit 3 may be column strobe
  output logic rdN,                        // read strobe
  output logic [1:0] wrN,                  // write strobes, [1] upper lane
  output logic [15:0] dataOut,             // write data lanes
  output logic [1:0] dataOutEnN,           // lane drive enable, low drives
  input wire logic [15:0] dataIn,          // read data lanes
  input wire logic waitN,                  // wait pin, low extends
  input wire logic externalWidthPin        // 1 forces 8-bit bus
);
  import csd_pkg::*;

  if (IO_TOP > WHOLE_LO) begin : g_chk
    $error("IO_TOP must not reach into the external space");
  end

  // ---------------------------------------------------------------
  // register file and AHB-Lite slave
  // ---------------------------------------------------------------
  logic [7:0] startVal_q [4];
  logic [7:0] mask_q [4];
  logic [7:0] ctrl_q [4];
  logic [7:0] defCtrl_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic hreadyout_q, hresp_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdMux;
  logic busy;
  logic [2:0] selArea_q;
  logic ioSel_q;
  wire addrOk = (haddr[31:8] == 24'h00_0000);
  wire take = hsel && htrans[1] && hready;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (addrOk) begin
      case (haddr[7:4])
        OFS_START[7:4]: rdMux[7:0] = startVal_q[haddr[3:2]];
        OFS_MASK[7:4]: rdMux[7:0] = mask_q[haddr[3:2]];
        OFS_CTRL[7:4]: rdMux[7:0] = ctrl_q[haddr[3:2]];
        default: begin
          if (haddr[7:0] == OFS_DEFAULT) begin
            rdMux[7:0] = defCtrl_q;
          end else if (haddr[7:0] == OFS_STATUS) begin
            rdMux[5:0] = {busy, ioSel_q, selArea_q, externalWidthPin};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wrPend_q <= take && hwrite && addrOk;
      if (take) begin
        wrAddr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata_q <= rdMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        startVal_q[i] <= START_RST;
        mask_q[i] <= MASK_RST;
      end
      ctrl_q[0] <= CTRL_RST;
      ctrl_q[1] <= CTRL_RST;
      ctrl_q[2] <= CTRL2_RST;
      ctrl_q[3] <= CTRL_RST;
      defCtrl_q <= DEF_RST;
    end else if (wrPend_q) begin
      case (wrAddr_q[7:4])
        OFS_START[7:4]: startVal_q[wrAddr_q[3:2]] <= hwdata[7:0];
        OFS_MASK[7:4]: mask_q[wrAddr_q[3:2]] <= hwdata[7:0];
        OFS_CTRL[7:4]: ctrl_q[wrAddr_q[3:2]] <= hwdata[7:0] & CTRL_WMASK[wrAddr_q[3:2]];
        default: begin
          if (wrAddr_q == OFS_DEFAULT) begin
            defCtrl_q <= hwdata[7:0] & DEF_WMASK;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // mask layout per area, result covers A23..A8; 1 means bit ignored
  function automatic logic [15:0] ignoreBits(input int area, input logic [7:0] m);
    case (area)
      0: ignoreBits = {3'b000, m[7:2], {6{m[1]}}, m[0]};
      1: ignoreBits = {2'b00, m[7:2], {7{m[1]}}, m[0]};
      default: ignoreBits = {1'b0, m, 7'h7F};
    endcase
  endfunction : ignoreBits

  logic [23:0] curAddr_q;
  logic [3:0] hit;
  for (genvar g = 0; g < 4; g++) begin : g_area
    // low start bits are zero, so starts land on 64K steps unless masked
    wire [15:0] diff = curAddr_q[23:8] ^ {startVal_q[g], 8'h00};
    wire cmp = (diff & ~ignoreBits(g, mask_q[g])) == 16'h0000;
    wire whole = (g == 2) && !ctrl_q[g][CTL_MODE];
    wire inWhole = (curAddr_q >= WHOLE_LO) && (curAddr_q <= WHOLE_HI);
    assign hit[g] = ctrl_q[g][CTL_EN] && (whole ? inWhole : cmp);
  end

  logic [2:0] area;
  logic [7:0] areaCtrl;
  always_comb begin
    area = AREA_DEFAULT;
    for (int i = 3; i >= 0; i--) begin
      if (hit[i]) begin
        area = 3'(i);
      end
    end
    areaCtrl = (area == AREA_DEFAULT) ? defCtrl_q : ctrl_q[area[1:0]];
  end
  wire isIo = curAddr_q < IO_TOP;
  wire wide = !externalWidthPin && !areaCtrl[CTL_BUSW];

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  csd_state_t state_q;
  logic write_q, word_q, upper_q, casCyc_q;
  logic [2:0] remN_q;
  logic [1:0] idx_q, waitCnt_q, waitMode_q;
  logic [31:0] wdShift_q, rdAcc_q;
  logic [3:0] selN_q;
  logic rdN_q, cpuDone_q;
  logic [1:0] wrN_q, enN_q;
  logic [15:0] dataOut_q;
  logic [23:0] extAddr_q;
  logic [31:0] cpuRdata_q;
  assign busy = (state_q != ST_IDLE);
  wire pieceWord = wide && !curAddr_q[0] && (remN_q >= 3'd2);
  wire pieceUpper = wide && curAddr_q[0];
  wire [2:0] step = word_q ? 3'd2 : 3'd1;
  wire hold = (waitCnt_q != 2'b00) || ((waitMode_q == WAIT_PIN) && !waitN);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      curAddr_q <= 24'h00_0000;
      write_q <= 1'b0;
      remN_q <= 3'd0;
      idx_q <= 2'd0;
      wdShift_q <= 32'h0000_0000;
      rdAcc_q <= 32'h0000_0000;
      word_q <= 1'b0;
      upper_q <= 1'b0;
      casCyc_q <= 1'b0;
      waitCnt_q <= 2'd0;
      waitMode_q <= WAIT_TWO;
      selArea_q <= AREA_DEFAULT;
      selN_q <= 4'hF;
      rdN_q <= 1'b1;
      wrN_q <= 2'b11;
      enN_q <= 2'b11;
      dataOut_q <= 16'h0000;
      extAddr_q <= 24'h00_0000;
      cpuDone_q <= 1'b0;
      cpuRdata_q <= 32'h0000_0000;
      ioSel_q <= 1'b0;
    end else begin
      cpuDone_q <= 1'b0;
      ioSel_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          selN_q <= 4'hF;
          if (cpuReq) begin
            curAddr_q <= cpuAddr;
            write_q <= cpuWrite;
            wdShift_q <= cpuWdata;
            rdAcc_q <= 32'h0000_0000;
            idx_q <= 2'd0;
            remN_q <= (cpuSize == SZ_WORD) ? 3'd4 : (cpuSize == SZ_HALF) ? 3'd2 : 3'd1;
            state_q <= ST_DEC;
          end
        end
        ST_DEC: begin
          selArea_q <= area;
          if (isIo) begin
            ioSel_q <= 1'b1;
            state_q <= ST_IO;
          end else begin
            extAddr_q <= curAddr_q;
            word_q <= pieceWord;
            upper_q <= pieceUpper;
            casCyc_q <= (area == 3'd3) && ctrl_q[3][CTL_WAVE];
            // a column strobe waits for the strobe phase, a select falls at once
            for (int i = 0; i < 4; i++) begin
              selN_q[i] <= !(area == 3'(i)) || (i == 3 && ctrl_q[3][CTL_WAVE]);
            end
            waitMode_q <= {areaCtrl[CTL_WAIT_HI], areaCtrl[CTL_WAIT_LO]};
            case ({areaCtrl[CTL_WAIT_HI], areaCtrl[CTL_WAIT_LO]})
              WAIT_TWO: waitCnt_q <= 2'd2;
              WAIT_ONE: waitCnt_q <= 2'd1;
              WAIT_PIN: waitCnt_q <= 2'd1;
              default: waitCnt_q <= 2'd0;
            endcase
            dataOut_q <= pieceWord ? wdShift_q[15:0] : {wdShift_q[7:0], wdShift_q[7:0]};
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (casCyc_q) begin
            selN_q[3] <= 1'b0;
          end
          rdN_q <= write_q;
          // only the lanes this piece uses are strobed and driven
          wrN_q <= {!(write_q && (word_q || upper_q)), !(write_q && !upper_q)};
          enN_q <= {!(write_q && (word_q || upper_q)), !(write_q && !upper_q)};
          state_q <= ST_STRB;
        end
        ST_STRB: begin
          if (waitCnt_q != 2'b00) begin
            waitCnt_q <= waitCnt_q - 2'd1;
          end else if (!hold) begin
            selN_q <= 4'hF;
            rdN_q <= 1'b1;
            wrN_q <= 2'b11;
            enN_q <= 2'b11;
            // unused lanes are never sampled
            if (word_q) begin
              rdAcc_q[{idx_q, 3'b000} +: 16] <= dataIn;
            end else begin
              rdAcc_q[{idx_q, 3'b000} +: 8] <= upper_q ? dataIn[15:8] : dataIn[7:0];
            end
            curAddr_q <= curAddr_q + {21'h00_0000, step};
            idx_q <= idx_q + step[1:0];
            remN_q <= remN_q - step;
            wdShift_q <= word_q ? {16'h0000, wdShift_q[31:16]} : {8'h00, wdShift_q[31:8]};
            if (remN_q == step) begin
              state_q <= ST_IDLE;
              cpuDone_q <= 1'b1;
              cpuRdata_q <= rdAcc_q;
              if (word_q) begin
                cpuRdata_q[{idx_q, 3'b000} +: 16] <= dataIn;
              end else begin
                cpuRdata_q[{idx_q, 3'b000} +: 8] <= upper_q ? dataIn[15:8] : dataIn[7:0];
              end
            end else begin
              state_q <= ST_DEC;
            end
          end
        end
        ST_IO: begin
          cpuDone_q <= 1'b1;
          cpuRdata_q <= 32'h0000_0000;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign cpuDone = cpuDone_q;
  assign cpuRdata = cpuRdata_q;
  assign ioSel = ioSel_q;
  assign extAddr = extAddr_q;
  assign areaSelectN = selN_q;
  assign rdN = rdN_q;
  assign wrN = wrN_q;
  assign dataOut = dataOut_q;
  assign dataOutEnN = enN_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence strbFall;
    state_q == ST_ADDR;
  endsequence
  sequence strbLow3;
    !(rdN_q && (&wrN_q)) [*3] ##1 (rdN_q && (&wrN_q));
  endsequence
  plainSel_a: assert property (state_q == ST_DEC && !isIo && area == 3'd3
    && !ctrl_q[3][CTL_WAVE] |=> !selN_q[3]) else $error("area 3 select not low");
  casDelay_a: assert property (strbFall and casCyc_q |-> selN_q[3] ##1 !selN_q[3])
    else $error("column strobe timing wrong");
  resetVals_a: assert property ($past(sys_rst) |-> !ctrl_q[3][CTL_WAVE] && !ctrl_q[2][CTL_MODE]
    && ctrl_q[2][CTL_EN] && !ctrl_q[0][CTL_EN] && startVal_q[1] == START_RST)
    else $error("reset values wrong");
  idleHigh_a: assert property (state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> &selN_q)
    else $error("select low outside a cycle");
  oneSel_a: assert property ($onehot0(~selN_q)) else $error("two selects low");
  twoWait_a: assert property (strbFall and (waitMode_q == WAIT_TWO) |=> strbLow3)
    else $error("two-wait cycle length wrong");
  noWait_a: assert property (strbFall and (waitMode_q == WAIT_NONE) |=> ##1 (rdN_q && &wrN_q))
    else $error("zero-wait cycle too long");
  laneDrive_a: assert property (enN_q == wrN_q) else $error("lane drive without strobe");
  ioQuiet_a: assert property (ioSel_q |-> &selN_q ##1 cpuDone_q)
    else $error("internal access reached a select");
endmodule : csd_chip_select
`default_nettype wire

// [bench/csd_mem_model.sv]
// behavioural external memory and peripheral on the area-select bus
`timescale 1ns/1ps
`default_nettype none
module csd_mem_model (
  input wire logic clk,              // system clock
  input wire logic sys_rst,          // synchronous reset, active high
  input wire logic [23:0] extAddr,   // address of the current piece
  input wire logic rdN,              // read strobe, active low
  input wire logic [1:0] wrN,        // write strobes, [1] upper lane
  input wire logic [15:0] dataOut,   // write lanes from the unit
  input wire logic [1:0] dataOutEnN, // lane drive enables, low drives
  input wire logic bus8,             // memory wired as an 8-bit part
  input wire logic [3:0] holdCyc,    // strobe cycles to hold the wait pin low
  output logic [15:0] dataIn,        // read lanes to the unit
  output logic waitN                 // wait pin, pulled up when idle
);
  logic [7:0] mem [256];
  logic [15:0] lastIn;
  logic [3:0] strobeCnt;
  logic [7:0] loIdx;
  logic [7:0] hiIdx;
  logic strobing;
  // -----------------------------------------------------------------
  // lanes
  // -----------------------------------------------------------------
  // an 8-bit part sits on the low lane at every address
  assign loIdx = bus8 ? extAddr[7:0] : {extAddr[7:1], 1'b0};
  assign hiIdx = {extAddr[7:1], 1'b1};
  // a released bus shows the inverse of the last value, so stale data never matches
  assign dataIn = !rdN ? {mem[hiIdx], mem[loIdx]} : ~lastIn;
  assign strobing = !rdN || (wrN != 2'b11);
  assign waitN = !strobing || (strobeCnt >= holdCyc);
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      strobeCnt <= 4'h0;
      lastIn <= 16'h0000;
    end else begin
      strobeCnt <= strobing ? ((strobeCnt == 4'hF) ? strobeCnt : strobeCnt + 4'h1) : 4'h0;
      if (!rdN) begin
        lastIn <= dataIn;
      end
      // only lanes both strobed and driven are stored
      if (!wrN[0] && !dataOutEnN[0]) begin
        mem[loIdx] <= dataOut[7:0];
      end
      if (!wrN[1] && !dataOutEnN[1]) begin
        mem[hiIdx] <= dataOut[15:8];
      end
    end
  end
endmodule : csd_mem_model
`default_nettype wire

// [bench/csd_chip_select_tb.sv]
// self-checking bench: registers over AHB-Lite, operand accesses against a memory model
`timescale 1ns/1ps
`default_nettype none
module csd_chip_select_tb;
  import csd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic cpuReq = 1'b0, cpuWrite = 1'b0, cpuDone, ioSel, rdN, waitN, ioSeen;
  logic widthPin = 1'b0, bus8 = 1'b0;
  logic [23:0] cpuAddr = 24'h00_0000, extAddr;
  logic [1:0] cpuSize = 2'b00, wrN, dataOutEnN, laneSeen;
  logic [31:0] cpuWdata = 32'h0000_0000, cpuRdata, lastRd;
  logic [3:0] areaSelectN, selSeen, holdCyc = 4'h0;
  logic [15:0] dataOut, dataIn;
  int nMismatch = 0, checks = 0, lastCyc, sel3Low;
  int wExp [4] = '{2, 1, 1, 0};
  assign hready = hreadyout;
  always #5 clk = ~clk;
  csd_chip_select dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpuReq(cpuReq),
    .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuSize(cpuSize), .cpuWdata(cpuWdata),
    .cpuDone(cpuDone), .cpuRdata(cpuRdata), .ioSel(ioSel), .extAddr(extAddr),
    .areaSelectN(areaSelectN), .rdN(rdN), .wrN(wrN), .dataOut(dataOut),
    .dataOutEnN(dataOutEnN), .dataIn(dataIn), .waitN(waitN), .externalWidthPin(widthPin));
  csd_mem_model mem_u (.clk(clk), .sys_rst(sys_rst), .extAddr(extAddr), .rdN(rdN),
    .wrN(wrN), .dataOut(dataOut), .dataOutEnN(dataOutEnN), .bus8(bus8),
    .holdCyc(holdCyc), .dataIn(dataIn), .waitN(waitN));
  // -----------------------------------------------------------------
  // monitor and shared tasks
  // -----------------------------------------------------------------
  always @(posedge clk) begin
    selSeen = selSeen | ~areaSelectN;
    laneSeen = laneSeen | ~dataOutEnN;
    ioSeen = ioSeen | ioSel;
    sel3Low = sel3Low + int'(!areaSelectN[3]);
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task conclude;
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task waitReady;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      nMismatch++;
      conclude;
    end
  endtask : waitReady
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    waitReady;
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady;
    lastRd = hrdata;
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(name, lastRd, exp);
  endtask : rdc
  function automatic logic [31:0] memWord(input int i);
    return {mem_u.mem[i + 3], mem_u.mem[i + 2], mem_u.mem[i + 1], mem_u.mem[i]};
  endfunction : memWord
  // one operand access; cycles counted from the edge that takes the request
  task op(input logic w, input logic [23:0] a, input logic [1:0] sz, input logic [31:0] wd,
          input logic [3:0] selExp, input int cycExp);
    cpuReq <= 1'b1;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuSize <= sz;
    cpuWdata <= wd;
    selSeen = 4'h0;
    laneSeen = 2'b00;
    ioSeen = 1'b0;
    sel3Low = 0;
    @(posedge clk);
    cpuReq <= 1'b0;
    lastCyc = 0;
    do begin
      @(posedge clk);
      lastCyc++;
    end while (cpuDone !== 1'b1 && lastCyc < 200);
    if (cpuDone !== 1'b1) begin
      nMismatch++;
      conclude;
    end
    lastRd = cpuRdata;
    check("select", {28'h000_0000, selSeen}, {28'h000_0000, selExp});
    if (cycExp >= 0) check("cycles", 32'(lastCyc), 32'(cycExp));
  endtask : op
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      rdc("start", OFS_START + 8'(4 * n), 32'h0000_00FF);
      rdc("mask", OFS_MASK + 8'(4 * n), 32'h0000_00FF);
      rdc("ctrl", OFS_CTRL + 8'(4 * n), (n == 2) ? 32'h0000_0010 : 32'h0000_0000);
    end
    rdc("default", OFS_DEFAULT, 32'h0000_0000);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    wr(OFS_START, 32'hFFFF_FF01);
    rdc("start0", OFS_START, 32'h0000_0001);
    op(1'b0, 24'h00_1000, SZ_BYTE, 32'h0, 4'b0100, 6);
    op(1'b0, 24'h00_0010, SZ_BYTE, 32'h0, 4'b0000, 3);
    check("io", {31'h0, ioSeen}, 32'h0000_0001);
    // area 0 as a 64K window at 010000h, 16-bit, no wait
    wr(OFS_MASK, 32'h0000_0007);
    wr(OFS_CTRL, 32'h0000_0013);
    op(1'b1, 24'h01_0004, SZ_WORD, 32'h4433_2211, 4'b0001, 7);
    check("memword", memWord(4), 32'h4433_2211);
    op(1'b1, 24'h01_0003, SZ_BYTE, 32'h0000_00A5, 4'b0001, 4);
    check("lanes", {30'h0, laneSeen}, 32'h0000_0002);
    op(1'b0, 24'h01_0003, SZ_HALF, 32'h0, 4'b0001, 7);
    check("halfodd", lastRd, 32'h0000_11A5);
    op(1'b0, 24'h02_0000, SZ_BYTE, 32'h0, 4'b0100, 6);
    wr(OFS_CTRL, 32'h0000_0003);
    op(1'b0, 24'h01_0004, SZ_BYTE, 32'h0, 4'b0100, 6);
    // area 2 by start and mask: only A23 compared
    wr(OFS_START + 8'h08, 32'h0000_0080);
    wr(OFS_CTRL + 8'h08, 32'h0000_0033);
    op(1'b0, 24'h90_0000, SZ_BYTE, 32'h0, 4'b0100, 4);
    wr(OFS_DEFAULT, 32'h0000_0003);
    op(1'b0, 24'h10_0000, SZ_BYTE, 32'h0, 4'b0000, 4);
    wr(OFS_CTRL + 8'h08, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_DEFAULT, 32'(c));
      op(1'b0, 24'h10_0000, SZ_BYTE, 32'h0, 4'b0000, 4 + wExp[c]);
    end
    holdCyc <= 4'h3;
    wr(OFS_DEFAULT, 32'h0000_0002);
    op(1'b0, 24'h10_0000, SZ_BYTE, 32'h0, 4'b0000, 7);
    check("pinwait", {31'h0, lastCyc > 5}, 32'h0000_0001);
    holdCyc <= 4'h0;
    // 8-bit by control bit, then by the width pin overriding a 16-bit setting
    bus8 <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h0000_0013 : 32'h0000_0017);
      widthPin <= 1'(k);
      op(1'b1, 24'h01_0004, SZ_WORD, 32'h8877_6655 + k, 4'b0001, 13);
      check("lanes8", {30'h0, laneSeen}, 32'h0000_0001);
      check("mem8", memWord(4), 32'h8877_6655 + k);
    end
    bus8 <= 1'b0;
    widthPin <= 1'b0;
    // area 1 with every bit compared: one 256-byte page at 020000h, miss falls to default
    wr(OFS_START + 8'h04, 32'h0000_0002);
    wr(OFS_MASK + 8'h04, 32'h0000_0000);
    wr(OFS_CTRL + 8'h04, 32'h0000_0013);
    op(1'b0, 24'h02_0000, SZ_BYTE, 32'h0, 4'b0010, 4);
    op(1'b0, 24'h02_0100, SZ_BYTE, 32'h0, 4'b0000, 5);
    // area 3 plain select versus column strobe
    wr(OFS_START + 8'h0C, 32'h0000_00C0);
    wr(OFS_MASK + 8'h0C, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL + 8'h0C, k ? 32'h0000_001B : 32'h0000_0013);
      op(1'b0, 24'hC0_0000, SZ_BYTE, 32'h0, 4'b1000, 4);
      check("sel3low", 32'(sel3Low), k ? 32'h0000_0001 : 32'h0000_0002);
    end
    check("idle", {28'h000_0000, areaSelectN}, 32'h0000_000F);
    conclude;
  end
endmodule : csd_chip_select_tb
`default_nettype wire
